// ### bench/ptm_checker.sv
// Purpose: Bus and pin relations of the periodic timer
// Assumes: Sees only the top ports, one clock domain
// Notes:   Bound to every instance of the timer
`timescale 1ns/1ps
`include "ptm_map.svh"

module ptm_checker #(
   parameter int CNT_W = 16
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer_output_pin,
   input wire logic        timer_output_pin_n
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_setup: assert property (
      psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (
      pready |=> !pready) else $error("ready longer than one cycle");
   a_err_unmapped: assert property (
      pready && paddr > `PTM_OFS_STATUS |-> pslverr)
      else $error("unmapped address not refused");
   a_ok_mapped: assert property (
      pready && paddr <= `PTM_OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped address refused");
   a_upper_zero: assert property (
      pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_ctrl_a_low: assert property (
      pready && !pwrite && paddr == `PTM_OFS_CTRL_A |-> prdata[2:0] == 3'h0)
      else $error("unused control bits read nonzero");
   a_rdata_hold: assert property (
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data changed without a read");
   a_pin_pair: assert property (
      timer_output_pin_n == !timer_output_pin)
      else $error("output pair not complementary");
endmodule

bind ptm_timer ptm_checker #(.CNT_W(CNT_W)) u_ptm_checker (
   .pclk               (pclk),
   .presetn            (presetn),
   .psel               (psel),
   .penable            (penable),
   .pwrite             (pwrite),
   .paddr              (paddr),
   .prdata             (prdata),
   .pready             (pready),
   .pslverr            (pslverr),
   .timer_output_pin   (timer_output_pin),
   .timer_output_pin_n (timer_output_pin_n)
);

// ### bench/tb_periodic_timer_control_regs.sv
// Purpose: Self-checking bench of the periodic timer
// Assumes: APB master waits on pready; external pin is the counter clock, except in the last case, which counts the high-speed clock
// Notes:   Pin-function cases run as table rows
`timescale 1ns/1ps
`include "ptm_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_periodic_timer_control_regs;
   // ************************************************************
   // Signals
   // ************************************************************
   typedef struct packed {
      logic [7:0] b;
      logic       pin0;
      logic       pin1;
      logic [7:0] cnt;
   } ptm_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        ext_pin = 1'b0;
   logic        cap_pin = 1'b0;
   logic        hs = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, pin, pin_n, flag_a, flag_p, cap_ev;
   logic [7:0]  r;
   logic        err;
   int          checks = 0, fails = 0, cyc = 0;
   int          a_cnt = 0, p_cnt = 0, ev_cnt = 0;
   ptm_row_t    rows [8] = '{'{8'h01, 1'b0, 1'b0, 8'h00},
      '{8'h11, 1'b0, 1'b0, 8'h00}, '{8'h21, 1'b0, 1'b1, 8'h00},
      '{8'h31, 1'b0, 1'b1, 8'h00}, '{8'h19, 1'b1, 1'b0, 8'h00},
      '{8'h29, 1'b1, 1'b1, 8'h00}, '{8'h25, 1'b1, 1'b0, 8'h00},
      '{8'h20, 1'b0, 1'b1, 8'h03}};

   ptm_timer #(.CNT_W(16)) u_ptm_timer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .high_speed_clock(hs),
      .sub_clock(1'b0), .external_clock_pin(ext_pin),
      .capture_input_pin(cap_pin), .timer_output_pin(pin),
      .timer_output_pin_n(pin_n), .compare_a_flag(flag_a),
      .compare_p_flag(flag_p), .capture_event(cap_ev));

   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (flag_a === 1'b1) a_cnt <= a_cnt + 1;
      if (flag_p === 1'b1) p_cnt <= p_cnt + 1;
      if (cap_ev === 1'b1) ev_cnt <= ev_cnt + 1;
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic stop_test();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ext(input int n);
      repeat (n) begin
         @(posedge pclk);
         ext_pin <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_pin <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) begin
         apb(1'b0, 12'(a), 8'h00);
         `CHK(r, 8'h00)
      end
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h87);
      apb(1'b0, `PTM_OFS_CTRL_A, 8'h00);
      `CHK(r, 8'h80)
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h00);
      apb(1'b1, `PTM_OFS_PER_HI, 8'ha5);
      apb(1'b0, `PTM_OFS_PER_HI, 8'h00);
      `CHK(r, 8'ha5)
      apb(1'b1, `PTM_OFS_PER_HI, 8'h00);
      apb(1'b1, `PTM_OFS_CNT_LO, 8'h77);
      apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
      `CHK(r, 8'h00)
      apb(1'b0, 12'h040, 8'h00);
      `CHK({err, r}, 9'h100)
      apb(1'b1, `PTM_OFS_CMPA_LO, 8'h03);
      foreach (rows[i]) begin
         apb(1'b1, `PTM_OFS_CTRL_B, rows[i].b);
         apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
         repeat (2) @(posedge pclk);
         `CHK(pin, rows[i].pin0)
         ext(3);
         `CHK(pin, rows[i].pin1)
         apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
         `CHK(r, rows[i].cnt)
         `CHK(a_cnt, i + 1)
         if (rows[i].b[0]) `CHK(p_cnt, 0)
         apb(1'b1, `PTM_OFS_CTRL_A, 8'h60);
      end
      apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
      `CHK(r, 8'h03)
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
      apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
      `CHK(r, 8'h00)
      ext(2);
      apb(1'b1, `PTM_OFS_CTRL_A, 8'he8);
      ext(2);
      apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
      `CHK(r, 8'h02)
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
      ext(1);
      apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
      `CHK(r, 8'h03)
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h60);
      apb(1'b1, `PTM_OFS_CTRL_B, 8'h52);
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
      cap_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      cap_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK(ev_cnt, 0)
      ext(1);
      `CHK(ev_cnt, 1)
      apb(1'b0, `PTM_OFS_STATUS, 8'h00);
      `CHK(r, 8'h01)
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h60);
      apb(1'b1, `PTM_OFS_PER_LO, 8'h05);
      apb(1'b1, `PTM_OFS_CTRL_B, 8'ha8);
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
      repeat (2) @(posedge pclk);
      `CHK(pin, 1'b1)
      ext(3);
      `CHK(pin, 1'b0)
      `CHK(pin_n, 1'b1)
      ext(2);
      `CHK(pin, 1'b1)
      `CHK(p_cnt, 1)
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h60);
      apb(1'b1, `PTM_OFS_CTRL_B, 8'hc0);
      apb(1'b1, `PTM_OFS_CTRL_A, 8'h28);
      hs <= 1'b1;
      repeat (32) @(posedge pclk);
      hs <= 1'b0;
      apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
      `CHK(r, 8'h02)
      stop_test();
   end
endmodule

// ### hdl/ptm_map.svh
// Purpose: Register offsets, field positions and reset values of the timer
// Assumes: APB byte addresses, one register per aligned word
// Notes:   Definitions only
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

`define PTM_OFS_CTRL_A    12'h000
`define PTM_OFS_CTRL_B    12'h004
`define PTM_OFS_CNT_LO    12'h008
`define PTM_OFS_CNT_HI    12'h00c
`define PTM_OFS_CMPA_LO   12'h010
`define PTM_OFS_CMPA_HI   12'h014
`define PTM_OFS_PER_LO    12'h018
`define PTM_OFS_PER_HI    12'h01c
`define PTM_OFS_STATUS    12'h020

`define PTM_CTRL_A_MASK   8'hf8
`define PTM_RST_BYTE      8'h00
`define PTM_RST_CNT       16'h0000
`define PTM_CNT_MAX       16'hffff

`define PTM_A_PAUSE       7
`define PTM_A_CKS_HI      6
`define PTM_A_CKS_LO      4
`define PTM_A_ON          3
`define PTM_B_MODE_HI     7
`define PTM_B_MODE_LO     6
`define PTM_B_PINF_HI     5
`define PTM_B_PINF_LO     4
`define PTM_B_INIT        3
`define PTM_B_INV         2
`define PTM_B_CAPSRC      1
`define PTM_B_CLRSEL      0

`define PTM_DIV4_LAST     2'h3
`define PTM_DIV16_LAST    4'hf
`define PTM_DIV64_LAST    6'h3f

`endif

// ### hdl/ptm_pkg.sv
// Purpose: Types shared by the periodic timer
// Assumes: Used with ptm_map.svh
// Notes:   No constants live here, only types
package ptm_pkg;

   typedef enum logic [1:0] {
      PTM_MODE_CMP,
      PTM_MODE_CAP,
      PTM_MODE_PWM,
      PTM_MODE_TMR
   } ptm_mode_t;

   typedef enum logic [2:0] {
      PTM_CK_SYS4,
      PTM_CK_SYS,
      PTM_CK_HI16,
      PTM_CK_HI64,
      PTM_CK_SUB0,
      PTM_CK_SUB1,
      PTM_CK_EXTR,
      PTM_CK_EXTF
   } ptm_clk_sel_t;

   typedef struct packed {
      logic         pause_control;
      ptm_clk_sel_t counter_clock_select;
      logic         timer_on;
      logic [2:0]   unused;
   } ptm_ctrl_a_t;

   typedef struct packed {
      ptm_mode_t    op_mode_select;
      logic [1:0]   pin_function_select;
      logic         output_init_level;
      logic         output_invert;
      logic         capture_source_select;
      logic         clear_select;
   } ptm_ctrl_b_t;

endpackage

// ### hdl/ptm_timer.sv
// Purpose: Register layer and counter core of a 16-bit periodic timer
// Assumes: All pins synchronous to pclk; sub_clock and high-speed clock
//          arrive as one-cycle enable pulses
// Notes:   APB slave, zero wait states, pslverr on unmapped addresses
`timescale 1ns/1ps
`include "ptm_map.svh"

module ptm_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        high_speed_clock,
   input  wire logic        sub_clock,
   input  wire logic        external_clock_pin,
   input  wire logic        capture_input_pin,
   output logic             timer_output_pin,
   output logic             timer_output_pin_n,
   output logic             compare_a_flag,
   output logic             compare_p_flag,
   output logic             capture_event
);

   if (CNT_W != 16) begin : g_bad_width
      $error("ptm_timer supports a 16-bit counter only");
   end

   //*******************************************************
   // Register file
   //*******************************************************
   ptm_pkg::ptm_ctrl_a_t ctrl_a_ff;
   ptm_pkg::ptm_ctrl_b_t ctrl_b_ff;
   logic [15:0]          cmpa_ff;
   logic [15:0]          per_ff;
   logic [15:0]          cnt_ff;
   logic [15:0]          cap_ff;
   logic                 on_d_ff;
   logic                 pin_ff;
   logic                 ext_d_ff;
   logic                 cap_d_ff;
   logic [1:0]           div4_ff;
   logic [3:0]           div16_ff;
   logic [5:0]           div64_ff;

   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;
   logic [7:0] rd_byte;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   function automatic logic [15:0] put_byte(input logic [15:0] old,
                                            input logic        hi,
                                            input logic [7:0]  b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   always_comb begin
      addr_ok = 1'b1;
      rd_byte = `PTM_RST_BYTE;
      case (paddr)
         `PTM_OFS_CTRL_A:  rd_byte = ctrl_a_ff & `PTM_CTRL_A_MASK;
         `PTM_OFS_CTRL_B:  rd_byte = ctrl_b_ff;
         `PTM_OFS_CNT_LO:  rd_byte = cnt_ff[7:0];
         `PTM_OFS_CNT_HI:  rd_byte = cnt_ff[15:8];
         `PTM_OFS_CMPA_LO: rd_byte = cmpa_ff[7:0];
         `PTM_OFS_CMPA_HI: rd_byte = cmpa_ff[15:8];
         `PTM_OFS_PER_LO:  rd_byte = per_ff[7:0];
         `PTM_OFS_PER_HI:  rd_byte = per_ff[15:8];
         `PTM_OFS_STATUS:  rd_byte = cap_ff[7:0];
         default:          addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_ff <= `PTM_RST_BYTE;
         ctrl_b_ff <= `PTM_RST_BYTE;
         cmpa_ff   <= `PTM_RST_CNT;
         per_ff    <= `PTM_RST_CNT;
      end else if (wr_en) begin
         case (paddr)
            `PTM_OFS_CTRL_A:  ctrl_a_ff <= pwdata[7:0] & `PTM_CTRL_A_MASK;
            `PTM_OFS_CTRL_B:  ctrl_b_ff <= pwdata[7:0];
            `PTM_OFS_CMPA_LO: cmpa_ff <= put_byte(cmpa_ff, 1'b0, pwdata[7:0]);
            `PTM_OFS_CMPA_HI: cmpa_ff <= put_byte(cmpa_ff, 1'b1, pwdata[7:0]);
            `PTM_OFS_PER_LO:  per_ff <= put_byte(per_ff, 1'b0, pwdata[7:0]);
            `PTM_OFS_PER_HI:  per_ff <= put_byte(per_ff, 1'b1, pwdata[7:0]);
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   //*******************************************************
   // Counter clock
   //*******************************************************
   logic tick;
   logic ext_rise;
   logic ext_fall;
   logic on;
   logic on_rise;

   assign on       = ctrl_a_ff.timer_on;
   assign on_rise  = on && !on_d_ff;
   assign ext_rise = external_clock_pin && !ext_d_ff;
   assign ext_fall = !external_clock_pin && ext_d_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div4_ff  <= 2'h0;
         div16_ff <= 4'h0;
         div64_ff <= 6'h0;
      end else begin
         div4_ff <= div4_ff + 2'h1;
         if (high_speed_clock) begin
            div16_ff <= div16_ff + 4'h1;
            div64_ff <= div64_ff + 6'h1;
         end
      end
   end

   always_comb begin
      case (ctrl_a_ff.counter_clock_select)
         ptm_pkg::PTM_CK_SYS4: tick = (div4_ff == `PTM_DIV4_LAST);
         ptm_pkg::PTM_CK_SYS:  tick = 1'b1;
         ptm_pkg::PTM_CK_HI16: tick = high_speed_clock &&
                                     (div16_ff == `PTM_DIV16_LAST);
         ptm_pkg::PTM_CK_HI64: tick = high_speed_clock &&
                                     (div64_ff == `PTM_DIV64_LAST);
         ptm_pkg::PTM_CK_SUB0: tick = sub_clock;
         ptm_pkg::PTM_CK_SUB1: tick = sub_clock;
         ptm_pkg::PTM_CK_EXTR: tick = ext_rise;
         ptm_pkg::PTM_CK_EXTF: tick = ext_fall;
         default:              tick = 1'b0;
      endcase
   end

   //*******************************************************
   // Counter, comparators and clear
   //*******************************************************
   logic run;
   logic cmp_like;
   logic match_a;
   logic match_p;
   logic ovf;
   logic clr_a;
   logic raise_a;
   logic raise_p;
   logic do_clr;

   assign run = on && !ctrl_a_ff.pause_control && tick;
   assign cmp_like = (ctrl_b_ff.op_mode_select == ptm_pkg::PTM_MODE_CMP) ||
                     (ctrl_b_ff.op_mode_select == ptm_pkg::PTM_MODE_TMR);
   assign clr_a   = cmp_like && ctrl_b_ff.clear_select;
   assign match_a = run && (cmpa_ff != `PTM_RST_CNT) &&
                    (cnt_ff + 16'h0001 == cmpa_ff);
   assign match_p = run && (per_ff != `PTM_RST_CNT) &&
                    (cnt_ff + 16'h0001 == per_ff);
   assign ovf     = run && (cnt_ff == `PTM_CNT_MAX);
   assign raise_a = match_a;
   assign raise_p = match_p && !clr_a;
   assign do_clr  = clr_a ? match_a :
                    (match_p || (ovf && per_ff == `PTM_RST_CNT));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff  <= `PTM_RST_CNT;
         on_d_ff <= 1'b0;
      end else begin
         on_d_ff <= on;
         if (on_rise) begin
            cnt_ff <= `PTM_RST_CNT;
         end else if (do_clr) begin
            cnt_ff <= `PTM_RST_CNT;
         end else if (run) begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
      end else begin
         compare_a_flag <= raise_a;
         compare_p_flag <= raise_p;
      end
   end

   //*******************************************************
   // Output pin
   //*******************************************************
   logic init;
   logic nxt_pin;
   logic [1:0] pinf;

   assign init = ctrl_b_ff.output_init_level;
   assign pinf = ctrl_b_ff.pin_function_select;

   always_comb begin
      nxt_pin = pin_ff;
      case (ctrl_b_ff.op_mode_select)
         ptm_pkg::PTM_MODE_CMP: begin
            if (on_rise) begin
               nxt_pin = init;
            end else if (match_a) begin
               case (pinf)
                  2'h1:    nxt_pin = 1'b0;
                  2'h2:    nxt_pin = 1'b1;
                  2'h3:    nxt_pin = !pin_ff;
                  default: nxt_pin = pin_ff;
               endcase
            end
         end
         ptm_pkg::PTM_MODE_PWM: begin
            case (pinf)
               2'h0:    nxt_pin = !init;
               2'h1:    nxt_pin = init;
               2'h2: begin
                  if (on_rise || match_p) begin
                     nxt_pin = init;
                  end else if (match_a) begin
                     nxt_pin = !init;
                  end
               end
               default: begin
                  if (on_rise) begin
                     nxt_pin = init;
                  end else if (match_a) begin
                     nxt_pin = !init;
                  end
               end
            endcase
         end
         default: nxt_pin = pin_ff;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_ff             <= 1'b0;
         timer_output_pin   <= 1'b0;
         timer_output_pin_n <= 1'b1;
      end else begin
         pin_ff <= nxt_pin;
         if (ctrl_b_ff.op_mode_select == ptm_pkg::PTM_MODE_TMR) begin
            timer_output_pin   <= nxt_pin;
            timer_output_pin_n <= !nxt_pin;
         end else begin
            timer_output_pin   <= nxt_pin ^ ctrl_b_ff.output_invert;
            timer_output_pin_n <= !(nxt_pin ^ ctrl_b_ff.output_invert);
         end
      end
   end

   //*******************************************************
   // Capture
   //*******************************************************
   logic cap_src;
   logic cap_hit;

   assign cap_src = ctrl_b_ff.capture_source_select ?
                    external_clock_pin : capture_input_pin;

   always_comb begin
      case (pinf)
         2'h0:    cap_hit = cap_src && !cap_d_ff;
         2'h1:    cap_hit = !cap_src && cap_d_ff;
         2'h2:    cap_hit = cap_src ^ cap_d_ff;
         default: cap_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_d_ff      <= 1'b0;
         cap_d_ff      <= 1'b0;
         cap_ff        <= `PTM_RST_CNT;
         capture_event <= 1'b0;
      end else begin
         ext_d_ff      <= external_clock_pin;
         cap_d_ff      <= cap_src;
         capture_event <= 1'b0;
         if (on && cap_hit &&
             ctrl_b_ff.op_mode_select == ptm_pkg::PTM_MODE_CAP) begin
            cap_ff        <= cnt_ff;
            capture_event <= 1'b1;
         end
      end
   end

endmodule
